/* core/ptg_timer.sv */
// Period timer top: prescaler, input delays, counter and PWM drive
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ptg_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_reset_input,
  output logic             pwm_out,
  output logic             postscaled_match_out
);
  typedef struct packed {
    logic [7:0] count_value;
    logic       pwm;
    logic       ers_prev;
    logic       run_prev;
    logic       hold_prev;
    logic       done;
    logic       match;
    logic [2:0] div;
  } ptg_core_t;

  ptg_core_t         st;
  ptg_core_t         next_st;
  ptg_pkg::ptg_cfg_t cfg;
  ptg_pkg::ptg_stat_t stat;
  logic              clear_on;
  logic              tick;
  logic [2:0]        ps_mask;
  logic              run_one;
  logic              run_two;
  logic              ers_one;
  logic              ers_two;
  logic              run;
  logic              ers;
  logic              count_en;
  logic              edge_rst;
  logic              lvl_hold;
  logic              lvl_mode;
  logic              one_shot;

  ptg_apb u_apb (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .clear_on (clear_on),
    .stat     (stat),
    .cfg      (cfg)
  );

  // Timer clock tick from prescaler, every cycle on instruction clock
  always_comb begin
    ps_mask = 3'((4'h1 << cfg.prescale_select) - 4'h1);
    tick    = !cfg.clk_sel || ((st.div & ps_mask) == ps_mask);
  end

  ptg_delay u_run_dly (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .d       (cfg.on),
    .q_one   (run_one),
    .q_two   (run_two)
  );

  ptg_delay u_ers_dly (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .d       (external_reset_input),
    .q_one   (ers_one),
    .q_two   (ers_two)
  );

  // Delay depth picked by clock source
  always_comb begin
    run = cfg.clk_sel ? run_two : run_one;
    ers = cfg.clk_sel ? ers_two : ers_one;
  end

  always_comb begin
    next_st  = st;
    clear_on = 1'b0;
    count_en = 1'b0;
    edge_rst = 1'b0;
    lvl_hold = 1'b0;
    lvl_mode = 1'b0;
    one_shot = 1'b0;
    next_st.match = 1'b0;
    next_st.div   = st.div + 3'h1;
    case (cfg.mode)
      ptg_pkg::MODE_SW_GATE: begin
        count_en = run;
      end
      ptg_pkg::MODE_GATE_HI: begin
        count_en = run && !ers;
      end
      ptg_pkg::MODE_GATE_LO: begin
        count_en = run && ers;
      end
      ptg_pkg::MODE_EDGE_ANY: begin
        count_en = run;
        edge_rst = run && (ers != st.ers_prev);
      end
      ptg_pkg::MODE_EDGE_RISE: begin
        count_en = run;
        edge_rst = run && ers && !st.ers_prev;
      end
      ptg_pkg::MODE_EDGE_FALL: begin
        count_en = run;
        edge_rst = run && !ers && st.ers_prev;
      end
      ptg_pkg::MODE_LVL_LOW: begin
        lvl_mode = 1'b1;
        lvl_hold = run && !ers;
        count_en = run && !lvl_hold;
      end
      ptg_pkg::MODE_LVL_HIGH: begin
        lvl_mode = 1'b1;
        lvl_hold = run && ers;
        count_en = run && !lvl_hold;
      end
      ptg_pkg::MODE_ONE_SHOT: begin
        one_shot = 1'b1;
        count_en = run && !st.done;
      end
      default: begin
        count_en = 1'b0;
      end
    endcase
    if (tick) begin
      next_st.ers_prev  = ers;
      next_st.run_prev  = run;
      next_st.hold_prev = lvl_hold;
      if (one_shot && !run) begin
        next_st.done = 1'b0;
      end
      if (!one_shot && !lvl_mode && !count_en && !edge_rst &&
          cfg.mode > ptg_pkg::MODE_ONE_SHOT) begin
        next_st.pwm = 1'b0;
      end else if (edge_rst) begin
        next_st.count_value = 8'h00;
        next_st.pwm = 1'b1;
      end else if (lvl_hold) begin
        next_st.count_value = 8'h00;
      end else if (count_en) begin
        if (st.count_value == cfg.period_value) begin
          next_st.count_value = 8'h00;
          next_st.match = 1'b1;
          if (one_shot) begin
            next_st.done = 1'b1;
            clear_on = 1'b1;
          end else begin
            next_st.pwm = 1'b1;
          end
        end else begin
          next_st.count_value = st.count_value + 8'h01;
          if (st.count_value == cfg.pulse_width_value) begin
            next_st.pwm = 1'b0;
          end
        end
      end
      if (lvl_mode && st.hold_prev && !lvl_hold && run) begin
        next_st.pwm = 1'b1;
      end
      if (one_shot && run && !st.run_prev && !st.done &&
          st.count_value == 8'h00) begin
        next_st.pwm = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stat.count_value    = st.count_value;
  assign stat.pwm            = st.pwm;
  assign stat.run            = run;
  assign stat.done           = st.done;
  assign pwm_out             = st.pwm;
  assign postscaled_match_out = st.match;
endmodule

/* core/ptg_pkg.sv */
// Constants and types for the period timer with gate, limit and one-shot
// Behaviour
// - Other clocks: two-tick delay on run, reset
// - Instruction clock: one-cycle delay on both
// - Software gate counts while run is set
// - Period match returns count to zero
// - Hardware gate stops on high or low
// - Gate halt stretches PWM period and pulse
// - Edge limit modes reset counter early
// - Early reset restarts PWM after delay
// - Level limit holds counter reset on level
// - Level limit ignores signal while run clear
// - Level reset clears two clocks after assertion
// - Count and PWM resume after match/release
// - PWM falls at pulse-width match, and is held low in a reserved mode
// - One-shot match clears counter and run
// - One-shot pause and resume by run bit
// - One-shot PWM from start to width match
// - Run cleared during drive stretches it
// - One-shot match stops counter at zero
package ptg_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_WIDTH  = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_CLK_BIT  = 4;
  localparam int CTRL_PS_LSB   = 5;
  localparam int CTRL_MODE_LSB = 8;
  localparam int STAT_PWM_BIT  = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] WIDTH_RESET  = 8'h00;
  localparam logic [4:0] MODE_RESET   = 5'h00;
  localparam logic [4:0] MODE_SW_GATE  = 5'h00;
  localparam logic [4:0] MODE_GATE_HI  = 5'h01;
  localparam logic [4:0] MODE_GATE_LO  = 5'h02;
  localparam logic [4:0] MODE_EDGE_ANY = 5'h03;
  localparam logic [4:0] MODE_EDGE_RISE = 5'h04;
  localparam logic [4:0] MODE_EDGE_FALL = 5'h05;
  localparam logic [4:0] MODE_LVL_LOW  = 5'h06;
  localparam logic [4:0] MODE_LVL_HIGH = 5'h07;
  localparam logic [4:0] MODE_ONE_SHOT = 5'h08;
  // Sync delay in timer ticks for instruction and other clocks
  localparam int SYNC_TICKS_INSTR = 1;
  localparam int SYNC_TICKS_OTHER = 2;

  typedef struct packed {
    logic       on;
    logic [4:0] mode;
    logic       clk_sel;
    logic [1:0] prescale_select;
    logic [7:0] period_value;
    logic [7:0] pulse_width_value;
  } ptg_cfg_t;

  typedef struct packed {
    logic [7:0] count_value;
    logic       pwm;
    logic       run;
    logic       done;
  } ptg_stat_t;
endpackage

/* core/ptg_delay.sv */
// Two-stage tick-advanced delay line for control inputs
`timescale 1ns/10ps
module ptg_delay (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic tick,
  input  wire logic d,
  output logic      q_one,
  output logic      q_two
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ptg_dly_t;

  ptg_dly_t st;
  ptg_dly_t next_st;

  always_comb begin
    next_st = st;
    if (tick) begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_one = st.s1;
  assign q_two = st.s2;
endmodule

/* core/ptg_apb.sv */
// APB register file for the period timer
`timescale 1ns/10ps
module ptg_apb (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          clear_on,
  input  ptg_pkg::ptg_stat_t stat,
  output ptg_pkg::ptg_cfg_t  cfg
);
  typedef struct packed {
    ptg_pkg::ptg_cfg_t cfg;
    logic [31:0]       rdata;
  } ptg_regs_t;

  ptg_regs_t st;
  ptg_regs_t next_st;
  logic      access;
  logic      mapped;

  always_comb begin
    next_st = st;
    access  = psel && penable;
    mapped  = (paddr == ptg_pkg::OFS_CTRL) ||
              (paddr == ptg_pkg::OFS_PERIOD) ||
              (paddr == ptg_pkg::OFS_WIDTH) ||
              (paddr == ptg_pkg::OFS_COUNT) ||
              (paddr == ptg_pkg::OFS_STATUS);
    if (clear_on) begin
      next_st.cfg.on = 1'b0;
    end
    if (access && pwrite) begin
      case (paddr)
        ptg_pkg::OFS_CTRL: begin
          next_st.cfg.on = pwdata[ptg_pkg::CTRL_ON_BIT];
          next_st.cfg.clk_sel = pwdata[ptg_pkg::CTRL_CLK_BIT];
          next_st.cfg.prescale_select =
            pwdata[ptg_pkg::CTRL_PS_LSB +: 2];
          next_st.cfg.mode = pwdata[ptg_pkg::CTRL_MODE_LSB +: 5];
        end
        ptg_pkg::OFS_PERIOD: next_st.cfg.period_value = pwdata[7:0];
        ptg_pkg::OFS_WIDTH: next_st.cfg.pulse_width_value = pwdata[7:0];
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        ptg_pkg::OFS_CTRL: begin
          next_st.rdata[ptg_pkg::CTRL_ON_BIT] = st.cfg.on;
          next_st.rdata[ptg_pkg::CTRL_CLK_BIT] = st.cfg.clk_sel;
          next_st.rdata[ptg_pkg::CTRL_PS_LSB +: 2] =
            st.cfg.prescale_select;
          next_st.rdata[ptg_pkg::CTRL_MODE_LSB +: 5] = st.cfg.mode;
        end
        ptg_pkg::OFS_PERIOD: next_st.rdata[7:0] = st.cfg.period_value;
        ptg_pkg::OFS_WIDTH:
          next_st.rdata[7:0] = st.cfg.pulse_width_value;
        ptg_pkg::OFS_COUNT: next_st.rdata[7:0] = stat.count_value;
        ptg_pkg::OFS_STATUS: begin
          next_st.rdata[ptg_pkg::STAT_PWM_BIT] = stat.pwm;
          next_st.rdata[ptg_pkg::STAT_RUN_BIT] = stat.run;
          next_st.rdata[ptg_pkg::STAT_DONE_BIT] = stat.done;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st.cfg.on                <= 1'b0;
      st.cfg.mode              <= ptg_pkg::MODE_RESET;
      st.cfg.clk_sel           <= 1'b0;
      st.cfg.prescale_select   <= 2'h0;
      st.cfg.period_value      <= ptg_pkg::PERIOD_RESET;
      st.cfg.pulse_width_value <= ptg_pkg::WIDTH_RESET;
      st.rdata                 <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign cfg     = st.cfg;
  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
endmodule

/* verification/ptg_ext_src.sv */
// External gate and reset source model
`timescale 1ns/10ps
module ptg_ext_src (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      external_reset_input
);
  // Level changes just after a clock edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      external_reset_input <= 1'b0;
    end else begin
      external_reset_input <= level;
    end
  end
endmodule

/* verification/ptg_timer_monitor.sv */
// Port checks for the period timer
`timescale 1ns/10ps
module ptg_monitor (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_reset_input,
  input wire logic        pwm_out,
  input wire logic        postscaled_match_out
);
  logic [4:0] mode_q, age, hi, lo;
  logic [7:0] per_q, wid_q;
  logic       acc, ok, m, st;
  assign acc = psel && penable;
  assign ok  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  assign m   = postscaled_match_out;
  assign st  = age == 5'h1f;
  // Snooped setup and settle counters
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= 5'h00;
      per_q  <= 8'hff;
      wid_q  <= 8'h00;
      age    <= 5'h00;
      hi     <= 5'h00;
      lo     <= 5'h00;
    end else begin
      if (acc && pwrite && paddr == 8'h00) begin
        mode_q <= pwdata[12:8];
      end
      if (acc && pwrite && paddr == 8'h04) begin
        per_q <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == 8'h08) begin
        wid_q <= pwdata[7:0];
      end
      age <= (acc && pwrite && paddr == 8'h00) ? 5'h00 : age + 5'(!st);
      hi  <= !external_reset_input ? 5'h00 : hi + 5'(hi != 5'h1f);
      lo  <= external_reset_input ? 5'h00 : lo + 5'(lo != 5'h1f);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ready_high_a: assert property (acc |-> pready)
    else $error("no ready in access");
  bad_addr_a: assert property (acc && !ok |-> pslverr)
    else $error("unmapped address not refused");
  good_addr_a: assert property (acc && ok |-> !pslverr)
    else $error("mapped address refused");
  match_pulse_a: assert property ($rose(m) && per_q != 8'h00 |=> !m)
    else $error("match pulse too long");
  free_pwm_a: assert property (st && mode_q < 5'h08 && m |-> pwm_out)
    else $error("pwm not set at match");
  shot_pwm_a: assert property (age > 5'h02 && mode_q == 5'h08 && m &&
    wid_q < per_q |-> !pwm_out)
    else $error("one-shot pwm high at period match");
  shot_once_a: assert property (mode_q == 5'h08 && m && per_q > 8'h02
    |=> !m [*4])
    else $error("one-shot runs on");
  reserved_mode_a: assert property (st && mode_q > 5'h08 |->
    !pwm_out && !m)
    else $error("reserved mode active");
  gate_stop_a: assert property (st && (mode_q == 5'h01 && hi == 5'h1f ||
    mode_q == 5'h02 && lo == 5'h1f) |-> !m)
    else $error("gated counter reached period");
  level_hold_a: assert property (st && per_q != 8'h00 &&
    (mode_q == 5'h06 && lo == 5'h1f || mode_q == 5'h07 && hi == 5'h1f)
    |-> !m)
    else $error("counter not held in reset");
  cover property (mode_q == 5'h08 && m);
  cover property (st && mode_q > 5'h08);
  cover property (acc && !ok);
endmodule
bind ptg_timer ptg_monitor mon (.*);

/* verification/tb_top.sv */
// Self-checking bench for the period timer
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        lvl     = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd, rd0;
  logic        pready, pslverr, pwm_out, postscaled_match_out, err;
  logic        external_reset_input;
  int          bad_count = 0, num_checks = 0, n, p;
  always #5 sys_clk = ~sys_clk;
  ptg_ext_src src (.sys_clk(sys_clk), .reset(reset), .level(lvl),
                   .external_reset_input(external_reset_input));
  ptg_timer uut (.*);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic quiet(input int c);
    repeat (c) begin
      @(negedge sys_clk);
      n += int'(postscaled_match_out === 1'b1);
      p += int'(pwm_out === 1'b1);
    end
  endtask
  task automatic gap(input int exp);
    int i;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (postscaled_match_out !== 1'b1 && i < 600);
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (postscaled_match_out !== 1'b1 && i < 600);
    check(i, exp);
    if (i >= 600) begin
      print_verdict();
    end
  endtask
  function automatic logic [31:0] cv(input logic [4:0] m, input logic on);
    return {19'h0, m, 7'h0, on};
  endfunction
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    xfer(1'b0, ptg_pkg::OFS_PERIOD, 32'h0);
    check(rd, 32'h000000ff);
    xfer(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    xfer(1'b1, ptg_pkg::OFS_PERIOD, 32'h5);
    xfer(1'b1, ptg_pkg::OFS_WIDTH, 32'h2);
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h00, 1'b1));
    gap(6);
    n = 0;
    p = 0;
    quiet(60);
    check(n, 10);
    check(p, 30);
    xfer(1'b1, ptg_pkg::OFS_CTRL, 32'h31);
    gap(12);
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h00, 1'b0));
    xfer(1'b0, ptg_pkg::OFS_COUNT, 32'h0);
    rd0 = rd;
    quiet(10);
    xfer(1'b0, ptg_pkg::OFS_COUNT, 32'h0);
    check(rd, rd0);
    xfer(1'b1, ptg_pkg::OFS_PERIOD, 32'h14);
    for (int m = 1; m < 8; m++) begin
      lvl <= (m == 1 || m == 7);
      xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'(m), 1'b1));
      n = 0;
      p = 0;
      if (m >= 3 && m <= 5) begin
        repeat (8) begin
          quiet(5);
          @(posedge sys_clk);
          lvl <= ~lvl;
        end
      end else begin
        quiet(40);
      end
      check(n, 0);
      if (m >= 3 && m <= 5) begin
        check(32'(p != 0), 32'h1);
      end
      @(posedge sys_clk);
      lvl <= ~lvl;
      gap(21);
    end
    xfer(1'b1, ptg_pkg::OFS_PERIOD, 32'h5);
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h08, 1'b1));
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h08, 1'b0));
    n = 0;
    quiet(20);
    check(n, 0);
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h08, 1'b1));
    quiet(30);
    check(n, 1);
    xfer(1'b0, ptg_pkg::OFS_CTRL, 32'h0);
    check(rd, cv(5'h08, 1'b0));
    xfer(1'b0, ptg_pkg::OFS_COUNT, 32'h0);
    check(rd, 32'h0);
    p = 0;
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h08, 1'b1));
    quiet(30);
    check(n, 2);
    check(32'(p != 0), 32'h1);
    check({31'h0, pwm_out}, 32'h0);
    xfer(1'b1, ptg_pkg::OFS_CTRL, cv(5'h09, 1'b1));
    quiet(4);
    n = 0;
    p = 0;
    quiet(40);
    check(n, 0);
    check(p, 0);
    print_verdict();
  end
endmodule
